// file: design/dacuc_cfg.svh
`ifndef DACUC_CFG_SVH
`define DACUC_CFG_SVH

// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define DACUC_IDX_DAC    3'h1
`define DACUC_IDX_CTL    3'h2
`define DACUC_IDX_CLR    3'h3
`define DACUC_IDX_SWC    3'h4
`define DACUC_IDX_STAT   3'h5

// ----------------------------------------
// field positions
// ----------------------------------------
`define DACUC_SWC_LOAD   0
`define DACUC_SWC_CLEAR  1
`define DACUC_SWC_RESET  2
`define DACUC_CTL_FB     1
`define DACUC_CTL_CLAMP  2
`define DACUC_CTL_TRI    3
`define DACUC_CTL_FMT    4
`define DACUC_FRM_RW     23
`define DACUC_FRM_AHI    22
`define DACUC_FRM_ALO    20

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define DACUC_DAC_RST    20'h80000
`define DACUC_CLR_RST    20'h00000
`define DACUC_FRM_LEN    5'h18
`define DACUC_PIN_RST    5'h1f
`define DACUC_RESP_OKAY  2'h0
`define DACUC_RESP_SLV   2'h2

`endif

// file: design/dacuc_pkg.sv
package dacuc_pkg;

  typedef logic [19:0] dacuc_code_t;
  typedef logic [31:0] dacuc_word_t;

  // output state seen by the converter stage
  typedef enum logic [1:0] {OST_NORMAL, OST_TRI, OST_CLAMP} dacuc_ostate_e;

  // whole state of the control block
  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          arready;
    logic          bvalid;
    logic          rvalid;
    logic [1:0]    bresp;
    logic [1:0]    rresp;
    dacuc_word_t   rdata;
    logic          aw_got;
    logic          aw_ok;
    logic [2:0]    aw_idx;
    logic          w_got;
    dacuc_code_t   wdata;
    logic [2:0]    wstrb;
    logic          sclk_d;
    logic          frm_d;
    logic [4:0]    cnt;
    logic [23:0]   sh;
    logic          ld_d;
    logic          clr_d;
    dacuc_code_t   dac_in;
    dacuc_code_t   dac_reg;
    dacuc_code_t   clr_val;
    logic          fb_sel;
    logic          clamp;
    logic          tri_st;
    logic          fmt;
    dacuc_code_t   code_out;
    logic          out_tri;
    logic          out_clamp;
    dacuc_ostate_e ostate;
  } dacuc_state_s;

endpackage

// file: design/dacuc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module dacuc_sync
#(
  parameter int             W       = 5,
  parameter logic [W-1:0]   RST_VAL = '1
)
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  if (W < 1)
  begin : g_bad_w
    $error("dacuc_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dacuc_sync_s;

  dacuc_sync_s s_r;
  dacuc_sync_s s_nxt;

  // ----------------------------------------
  // two-stage pin synchroniser
  // ----------------------------------------
  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= {RST_VAL, RST_VAL};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;

endmodule // dacuc_sync

`default_nettype wire

// file: design/dacuc_top.sv
// What this block does
// - control bits act like pulsing pins low
// - load bit moves pending value to DAC
// - clear bit copies clear value to DAC
// - output code follows selected register coding
// - reset bit restores device power-on state
// - clear ignored while load pin low
// - load ignored while clear pin low
// - power-on: defaults, tristate, output clamped
// - hold clamp until control register written
// - unclamped output starts at negative reference
// - decode tristate and clamp into output state
// - clamp forces tristate whatever tristate bit
// - coding select resets to twos complement
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dacuc_cfg.svh"

module dacuc_top
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire dacuc_pkg::dacuc_word_t s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output dacuc_pkg::dacuc_word_t s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              link_sclk,
  input  wire logic              link_frame_n,
  input  wire logic              link_sdin,
  input  wire logic              load_strobe_n,
  input  wire logic              clear_strobe_n,
  output dacuc_pkg::dacuc_code_t dac_code,
  output logic                   output_tristate,
  output logic                   output_clamp,
  output logic                   feedback_resistor_select,
  output dacuc_pkg::dacuc_ostate_e output_state
);
  import dacuc_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (ADDR_W < 5 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("dacuc_top: ADDR_W must lie in 5..32");
  end

  dacuc_state_s s_r;
  dacuc_state_s s_nxt;

  logic [4:0] pin_q;
  logic       sclk_q;
  logic       frm_q;
  logic       sdin_q;
  logic       ld_q;
  logic       clr_q;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  dacuc_sync
  #(
    .W       (5),
    .RST_VAL (`DACUC_PIN_RST)
  )
  u_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({link_sclk, link_frame_n, link_sdin,
               load_strobe_n, clear_strobe_n}),
    .q       (pin_q)
  );

  assign sclk_q = pin_q[4];
  assign frm_q  = pin_q[3];
  assign sdin_q = pin_q[2];
  assign ld_q   = pin_q[1];
  assign clr_q  = pin_q[0];

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // bus address to {valid, register index}
  function automatic logic [3:0] addr_dec(input logic [ADDR_W-1:0] a);
    logic [2:0] idx;
    logic       ok;
    idx = a[4:2];
    ok  = (a[1:0] == 2'h0) && ((a >> 5) == '0) &&
          (idx >= `DACUC_IDX_DAC) && (idx <= `DACUC_IDX_STAT);
    return {ok, idx};
  endfunction

  // device part of the power-on state
  function automatic dacuc_state_s dev_por(input dacuc_state_s x);
    dacuc_state_s y;
    y         = x;
    y.dac_in  = `DACUC_DAC_RST;
    y.dac_reg = `DACUC_DAC_RST; // reads as negative reference
    y.clr_val = `DACUC_CLR_RST;
    y.fb_sel  = 1'b1;
    y.clamp   = 1'b1;          // clamped and tristated
    y.tri_st  = 1'b1;
    y.fmt     = 1'b0;          // twos complement
    return y;
  endfunction

  // byte lanes to a 20-bit mask
  function automatic dacuc_code_t lane_mask(input logic [2:0] st);
    return {{4{st[2]}}, {8{st[1]}}, {8{st[0]}}};
  endfunction

  // register write into a state copy, masked per lane
  function automatic dacuc_state_s reg_wr(input dacuc_state_s x, input logic [2:0] idx,
                                          input dacuc_code_t d, input dacuc_code_t m);
    dacuc_state_s y;
    y = x;
    case (idx)
      `DACUC_IDX_DAC: y.dac_in  = (x.dac_in & ~m) | (d & m);  // pending until a load
      `DACUC_IDX_CLR: y.clr_val = (x.clr_val & ~m) | (d & m);
      `DACUC_IDX_CTL:
      begin
        if (m[0])
        begin
          y.fb_sel = d[`DACUC_CTL_FB];
          y.clamp  = d[`DACUC_CTL_CLAMP]; // only way out of the clamp
          y.tri_st = d[`DACUC_CTL_TRI];
          y.fmt    = d[`DACUC_CTL_FMT];
        end
      end
      default: y = x;
    endcase
    return y;
  endfunction

  // strobe bits of a write, zero for other registers
  function automatic logic [2:0] swc_dec(input logic [2:0] idx, input dacuc_code_t d,
                                         input dacuc_code_t m);
    logic [2:0] b;
    b = 3'h0;
    if (idx == `DACUC_IDX_SWC)
    begin
      b = d[2:0] & m[2:0];
    end
    return b;
  endfunction

  // converter view of the stored state
  function automatic dacuc_state_s out_dec(input dacuc_state_s x);
    dacuc_state_s y;
    y           = x;
    y.out_clamp = x.clamp;
    y.out_tri   = x.clamp || x.tri_st; // clamp overrules tristate
    y.ostate    = x.clamp ? OST_CLAMP : (x.tri_st ? OST_TRI : OST_NORMAL);
    // offset binary passes, twos complement flips the sign bit
    y.code_out  = x.fmt ? x.dac_reg : {~x.dac_reg[19], x.dac_reg[18:0]};
    return y;
  endfunction

  // whole reset state: bus idle, pins idle high, device at power-on
  function automatic dacuc_state_s rst_state();
    dacuc_state_s y;
    y        = '0;
    y.sclk_d = 1'b1;
    y.frm_d  = 1'b1;
    y.ld_d   = 1'b1;
    y.clr_d  = 1'b1;
    y        = dev_por(y);
    return out_dec(y);
  endfunction

  localparam dacuc_state_s ST_RST = rst_state();

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb
  begin
    logic        ld_fall;
    logic        clr_fall;
    logic        sclk_fall;
    logic        frm_fall;
    logic        frm_rise;
    logic        ser_wr;
    logic        axi_wr;
    logic        wr_en;
    logic [2:0]  wr_idx;
    dacuc_code_t wr_d;
    dacuc_code_t wr_m;
    logic [2:0]  swc;
    logic        ld_ev;
    logic        clr_ev;
    logic [3:0]  wdec;
    logic [3:0]  rdec;
    dacuc_word_t rd;

    // pin edges against the previous sample
    s_nxt     = s_r;
    ld_fall   = s_r.ld_d && !ld_q;
    clr_fall  = s_r.clr_d && !clr_q;
    sclk_fall = s_r.sclk_d && !sclk_q;
    frm_fall  = s_r.frm_d && !frm_q;
    frm_rise  = !s_r.frm_d && frm_q;
    // a complete write frame ends on the frame edge
    ser_wr    = frm_rise && (s_r.cnt == `DACUC_FRM_LEN) && !s_r.sh[`DACUC_FRM_RW];
    axi_wr    = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    wr_en     = axi_wr && s_r.aw_ok;
    wr_idx    = s_r.aw_idx;
    wr_d      = s_r.wdata;
    wr_m      = lane_mask(s_r.wstrb);
    // strobe bits from either access path
    swc       = (wr_en ? swc_dec(wr_idx, wr_d, wr_m) : 3'h0) |
                (ser_wr ? swc_dec(s_r.sh[`DACUC_FRM_AHI:`DACUC_FRM_ALO], s_r.sh[19:0], '1)
                        : 3'h0);
    ld_ev     = (swc[`DACUC_SWC_LOAD] || ld_fall) && clr_q;
    clr_ev    = (swc[`DACUC_SWC_CLEAR] || clr_fall) && ld_q;
    wdec      = addr_dec(s_axi_awaddr);
    rdec      = addr_dec(s_axi_araddr);
    rd        = '0;

    // edge detector history
    s_nxt.ld_d   = ld_q;
    s_nxt.clr_d  = clr_q;
    s_nxt.sclk_d = sclk_q;
    s_nxt.frm_d  = frm_q;

    // serial shifter, msb first on falling link clock
    if (frm_fall)
    begin
      s_nxt.cnt = 5'h00;
      s_nxt.sh  = 24'h000000;
    end
    else if (!frm_q && sclk_fall && (s_r.cnt != `DACUC_FRM_LEN))
    begin
      s_nxt.cnt = s_r.cnt + 5'h01;
      s_nxt.sh  = {s_r.sh[22:0], sdin_q};
    end
    if (ser_wr)
    begin
      s_nxt = reg_wr(s_nxt, s_r.sh[`DACUC_FRM_AHI:`DACUC_FRM_ALO], s_r.sh[19:0], '1);
    end

    // write address and data, taken in either order
    if (s_axi_awvalid && s_r.awready)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_ok  = wdec[3];
      s_nxt.aw_idx = wdec[2:0];
    end
    if (s_axi_wvalid && s_r.wready)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata[19:0];
      s_nxt.wstrb = s_axi_wstrb[2:0];
    end
    // both halves in hand: store and answer
    if (axi_wr)
    begin
      if (wr_en)
      begin
        s_nxt = reg_wr(s_nxt, wr_idx, wr_d, wr_m);
      end
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = s_r.aw_ok ? `DACUC_RESP_OKAY : `DACUC_RESP_SLV;
    end
    else if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid = 1'b0;
    end

    // read decode; the strobe register reads as zero
    case (rdec[2:0])
      `DACUC_IDX_DAC:  rd = {12'h000, s_r.dac_reg};
      `DACUC_IDX_CTL:  rd = {27'h0000000, s_r.fmt, s_r.tri_st, s_r.clamp, s_r.fb_sel, 1'b0};
      `DACUC_IDX_CLR:  rd = {12'h000, s_r.clr_val};
      `DACUC_IDX_STAT: rd = {30'h00000000, s_r.ostate};
      default:         rd = '0;
    endcase
    if (s_axi_arvalid && s_r.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rdec[3] ? rd : '0;
      s_nxt.rresp  = rdec[3] ? `DACUC_RESP_OKAY : `DACUC_RESP_SLV;
    end
    else if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid = 1'b0;
    end

    // strobes into the DAC register; clear wins a tie
    if (ld_ev)
    begin
      s_nxt.dac_reg = s_nxt.dac_in;
    end
    if (clr_ev)
    begin
      s_nxt.dac_reg = s_nxt.clr_val;
    end
    // software reset leaves the bus answer running
    if (swc[`DACUC_SWC_RESET])
    begin
      s_nxt = dev_por(s_nxt);
    end

    // ready follows what is still held
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
    s_nxt         = out_dec(s_nxt);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= ST_RST; // power-on state
    end
    else
    begin
      s_r <= s_nxt;
    end
  end


  // ----------------------------------------
  // outputs straight from the state register
  // ----------------------------------------
  assign s_axi_awready            = s_r.awready;
  assign s_axi_wready             = s_r.wready;
  assign s_axi_bresp              = s_r.bresp;
  assign s_axi_bvalid             = s_r.bvalid;
  assign s_axi_arready            = s_r.arready;
  assign s_axi_rdata              = s_r.rdata;
  assign s_axi_rresp              = s_r.rresp;
  assign s_axi_rvalid             = s_r.rvalid;
  assign dac_code                 = s_r.code_out;
  assign output_tristate          = s_r.out_tri;
  assign output_clamp             = s_r.out_clamp;
  assign feedback_resistor_select = s_r.fb_sel;
  assign output_state             = s_r.ostate;

endmodule // dacuc_top

`default_nettype wire

// file: dv/dacuc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dacuc_chk
(
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire logic [1:0]               s_axi_rresp,
  input wire dacuc_pkg::dacuc_word_t   s_axi_rdata,
  input wire logic                     output_tristate,
  input wire logic                     output_clamp,
  input wire dacuc_pkg::dacuc_ostate_e output_state
);
  import dacuc_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // output state and bus handshake
  // ----
  property p_por; $rose(aresetn) |-> output_clamp && output_tristate; endproperty
  a_por: assert property (p_por) else $error("no clamp after reset");
  property p_clst; output_clamp |-> output_state == OST_CLAMP; endproperty
  a_clst: assert property (p_clst) else $error("clamp state wrong");
  property p_cltri; output_clamp |-> output_tristate; endproperty
  a_cltri: assert property (p_cltri) else $error("clamp without tristate");
  property p_norm; output_state == OST_NORMAL |-> !output_tristate && !output_clamp; endproperty
  a_norm: assert property (p_norm) else $error("normal state wrong");
  property p_tri; output_state == OST_TRI |-> output_tristate && !output_clamp; endproperty
  a_tri: assert property (p_tri) else $error("tristate state wrong");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_wans; s_axi_awvalid && s_axi_wvalid |-> ##[0:20] s_axi_bvalid; endproperty
  a_wans: assert property (p_wans) else $error("write not answered");
  c_norm: cover property (output_state == OST_NORMAL);
  c_tri: cover property (output_state == OST_TRI);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // dacuc_chk
`default_nettype wire

// file: dv/dacuc_host.sv
`timescale 1ns/1ps
`default_nettype none
module dacuc_host
(
  output logic sclk,
  output logic frame_n,
  output logic sdin
);
  // ----
  // serial host, msb first, clock still between frames
  // ----
  initial
  begin
    sclk = 1'b1;
    frame_n = 1'b1;
    sdin = 1'b0;
  end
  task automatic send(input logic [23:0] f);
    #3 frame_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      #40 sdin = f[i];
      #40 sclk = 1'b0;
      #80 sclk = 1'b1;
    end
    #80 frame_n = 1'b1;
    sdin = ~sdin; // released line shows no stale bit
  endtask
endmodule // dacuc_host
`default_nettype wire

// file: dv/dacuc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dacuc_top_tb;
  import dacuc_pkg::*;
  logic aclk, aresetn, awv, wv, bry, arv, rry, ld_n, clr_n;
  logic awr, wr_r, bv, arr, rv, tri_o, clamp, fb, sclk, frm, sdin;
  logic [7:0] aw, ar;
  logic [31:0] wd, rdat, v;
  logic [1:0] bresp, rresp, r;
  dacuc_code_t dac;
  dacuc_ostate_e ost;
  int miscompares, total_checks, cyc;
  logic [31:0] ctl [4] = '{32'h12, 32'h8, 32'h4, 32'hc};
  dacuc_ostate_e est [4] = '{OST_NORMAL, OST_TRI, OST_CLAMP, OST_CLAMP};
  dacuc_host host (.sclk(sclk), .frame_n(frm), .sdin(sdin));
  dacuc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .link_sclk(sclk),
    .link_frame_n(frm), .link_sdin(sdin), .load_strobe_n(ld_n), .clear_strobe_n(clr_n),
    .dac_code(dac), .output_tristate(tri_o), .output_clamp(clamp),
    .feedback_resistor_select(fb), .output_state(ost));
  // ----
  // bus tasks and compare
  // ----
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] i, input logic [31:0] d);
    aw <= {3'h0, i, 2'h0};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
    bry <= 1'b0;
    repeat (6) @(posedge aclk); // let pins and outputs settle
  endtask
  task automatic rd(input logic [2:0] i);
    ar <= {3'h0, i, 2'h0};
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    v = rdat;
    r = rresp;
    rry <= 1'b0;
    @(posedge aclk);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // clock, timeout, sequence
  // ----
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      print_verdict;
    end
  end
  initial
  begin
    {aresetn, awv, wv, bry, arv, rry, aw, ar, wd} = '0;
    {ld_n, clr_n} = 2'h3;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("clamp", clamp, 1);
    chk("state", ost, OST_CLAMP);
    rd(3'h7);
    chk("rresp", r, 2'h2);
    for (int k = 0; k < 4; k++)
    begin
      wr(3'h2, ctl[k]);
      chk("state", ost, est[k]);
      chk("fb", fb, ctl[k][1]);
      chk("tri", tri_o, k > 0);
    end
    wr(3'h2, 32'h12);
    host.send({1'b0, 3'h3, 20'h12345});
    repeat (6) @(posedge aclk);
    rd(3'h3);
    chk("clrval", v[19:0], 20'h12345);
    wr(3'h4, 32'h2);
    chk("dac", dac, 20'h12345);
    wr(3'h2, 32'h2); // twos complement shows as msb flip
    chk("dac", dac, 20'h92345);
    wr(3'h1, 32'habc);
    clr_n <= 1'b0;
    repeat (3) @(posedge aclk); // pin passes its synchroniser
    wr(3'h4, 32'h1);
    chk("dac", dac, 20'h92345);
    clr_n <= 1'b1;
    repeat (3) @(posedge aclk);
    wr(3'h4, 32'h1);
    chk("dac", dac, 20'h80abc);
    ld_n <= 1'b0;
    repeat (3) @(posedge aclk);
    wr(3'h4, 32'h2);
    chk("dac", dac, 20'h80abc);
    ld_n <= 1'b1;
    wr(3'h4, 32'h4);
    chk("clamp", clamp, 1);
    rd(3'h3);
    chk("clrval", v[19:0], 20'h0);
    print_verdict;
  end
endmodule // dacuc_top_tb
bind dacuc_top dacuc_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata), .output_tristate(output_tristate),
  .output_clamp(output_clamp), .output_state(output_state));
`default_nettype wire
